// ### design/fetch_addr_gen.sv
// Forms the memory fetch address of a selected list pointer.
// Assumes pointer inputs come from flip-flops.
`timescale 1ns/100ps
`include "list_ptr_map.svh"
module fetch_addr_gen
  import list_ptr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        req_i,
  input  list_sel_e        sel_i,
  input  wire logic [31:0] comm_i,
  input  wire logic [31:0] per_i,
  input  wire logic [31:0] ctl_i,
  input  wire logic [31:0] blk_i,
  output logic      [31:0] addr_o,
  output logic             valid_o
);

  logic [31:0] addr_next;

  always_comb begin
    unique case (sel_i)
      LIST_COMM:     addr_next = pad_ptr(comm_i, `LP_COMM_LSB);
      LIST_PERIODIC: addr_next = pad_ptr(per_i, `LP_ED_LSB);
      LIST_CONTROL:  addr_next = pad_ptr(ctl_i, `LP_ED_LSB);
      LIST_BULK:     addr_next = pad_ptr(blk_i, `LP_ED_LSB);
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_o <= `LP_PTR_RST;
    end else if (clk_en_i && req_i) begin
      addr_o <= addr_next;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valid_o <= 1'b0;
    end else if (clk_en_i) begin
      valid_o <= req_i;
    end
  end

endmodule : fetch_addr_gen

// ### design/ohci_list_pointer_regs.sv
// List pointer register bank of a host controller.
// Assumes a one-cycle register port and a list walker that
// reports each advance with a one-cycle strobe.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "list_ptr_map.svh"
module ohci_list_pointer_regs
  import list_ptr_pkg::*;
#(
  parameter int unsigned ADDR_W = `LP_OFF_W
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic              periodic_upd_i,
  input  wire logic [31:0]       periodic_ptr_i,
  input  wire logic              control_upd_i,
  input  wire logic [31:0]       control_ptr_i,
  input  wire logic              bulk_upd_i,
  input  wire logic [31:0]       bulk_ptr_i,
  input  wire logic              fetch_req_i,
  input  wire logic [1:0]        fetch_sel_i,
  output logic      [31:0]       fetch_addr_o,
  output logic                   fetch_valid_o,
  output logic      [31:0]       comm_base_o,
  output logic      [31:0]       control_head_ptr_o,
  output logic      [31:0]       bulk_head_ptr_o,
  output logic                   control_list_end_o,
  output logic                   bulk_list_end_o
);

  if (ADDR_W < `LP_OFF_W) begin : g_bad_addr_w
    $error("ohci_list_pointer_regs: ADDR_W too small");
  end

  // ----------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_idx(logic [ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = `LP_IDX_NONE;
    if ((a >> `LP_OFF_W) == '0) begin
      case (a[`LP_OFF_W-1:0])
        `LP_OFF_COMM_BASE: idx = `LP_IDX_COMM;
        `LP_OFF_PER_CUR:   idx = `LP_IDX_PER_CUR;
        `LP_OFF_CTL_HEAD:  idx = `LP_IDX_CTL_HEAD;
        `LP_OFF_CTL_CUR:   idx = `LP_IDX_CTL_CUR;
        `LP_OFF_BLK_HEAD:  idx = `LP_IDX_BLK_HEAD;
        `LP_OFF_BLK_CUR:   idx = `LP_IDX_BLK_CUR;
        default:           idx = `LP_IDX_NONE;
      endcase
    end
    return idx;
  endfunction : reg_idx

  logic [2:0]  wr_idx;
  logic [2:0]  rd_idx;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [5:0]  hw_we_vec;
  logic [31:0] hw_data  [`LP_NUM_REGS];
  logic [31:0] ptr_q    [`LP_NUM_REGS];
  logic [5:0]  end_q;

  assign wr_idx = reg_idx(reg_addr_i);
  assign rd_idx = reg_idx(reg_addr_i);

  // ----------------------------------------------------------------
  // Hardware advance sources.
  // ----------------------------------------------------------------
  assign hw_we_vec = {bulk_upd_i, 1'b0, control_upd_i, 1'b0, periodic_upd_i, 1'b0};
  assign hw_data[`LP_IDX_COMM]     = `LP_PTR_RST;
  assign hw_data[`LP_IDX_PER_CUR]  = periodic_ptr_i;
  assign hw_data[`LP_IDX_CTL_HEAD] = `LP_PTR_RST;
  assign hw_data[`LP_IDX_CTL_CUR]  = control_ptr_i;
  assign hw_data[`LP_IDX_BLK_HEAD] = `LP_PTR_RST;
  assign hw_data[`LP_IDX_BLK_CUR]  = bulk_ptr_i;

  // ----------------------------------------------------------------
  // Pointer registers.
  // ----------------------------------------------------------------
  ptr_port_if pif [`LP_NUM_REGS] ();

  for (genvar gi = 0; gi < `LP_NUM_REGS; gi++) begin : g_reg
    localparam int unsigned LSB_G = (gi == 0) ? `LP_COMM_LSB : `LP_ED_LSB;
    localparam bit          WR_G  = (gi != 1);

    ptr_field_reg #(
      .LSB   (LSB_G),
      .SW_WR (WR_G)
    ) u_reg (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .clk_en_i  (clk_en_i),
      .p         (pif[gi])
    );

    assign pif[gi].sw_we    = reg_we_i && (wr_idx == 3'(gi));
    assign pif[gi].sw_wdata = reg_wdata_i;
    assign pif[gi].hw_we    = hw_we_vec[gi];
    assign pif[gi].hw_wdata = hw_data[gi];
    assign ptr_q[gi]        = pif[gi].ptr;
    assign end_q[gi]        = pif[gi].at_end;
  end

  // ----------------------------------------------------------------
  // Read port.
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = `LP_PTR_RST;
    if (reg_re_i && rd_idx != `LP_IDX_NONE) begin
      rdata_next = ptr_q[rd_idx];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= `LP_PTR_RST;
    end else if (clk_en_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // Fetch address.
  // ----------------------------------------------------------------
  fetch_addr_gen u_fetch (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .req_i     (fetch_req_i),
    .sel_i     (list_sel_e'(fetch_sel_i)),
    .comm_i    (ptr_q[`LP_IDX_COMM]),
    .per_i     (ptr_q[`LP_IDX_PER_CUR]),
    .ctl_i     (ptr_q[`LP_IDX_CTL_CUR]),
    .blk_i     (ptr_q[`LP_IDX_BLK_CUR]),
    .addr_o    (fetch_addr_o),
    .valid_o   (fetch_valid_o)
  );

  // ----------------------------------------------------------------
  // Walker view.
  // ----------------------------------------------------------------
  assign comm_base_o        = ptr_q[`LP_IDX_COMM];
  assign control_head_ptr_o = ptr_q[`LP_IDX_CTL_HEAD];
  assign bulk_head_ptr_o    = ptr_q[`LP_IDX_BLK_HEAD];
  assign control_list_end_o = end_q[`LP_IDX_CTL_CUR];
  assign bulk_list_end_o    = end_q[`LP_IDX_BLK_CUR];

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_comm_load;
    clk_en_i && reg_we_i && wr_idx == `LP_IDX_COMM
      |=> comm_base_o == {$past(reg_wdata_i[31:8]), 8'h00};
  endproperty
  a_comm_load: assert property (p_comm_load)
    else $error("base load wrong");

  property p_per_follow;
    clk_en_i && periodic_upd_i
      |=> ptr_q[`LP_IDX_PER_CUR] == {$past(periodic_ptr_i[31:4]), 4'h0};
  endproperty
  a_per_follow: assert property (p_per_follow)
    else $error("periodic pointer not advanced");

  property p_per_ro;
    clk_en_i && reg_we_i && wr_idx == `LP_IDX_PER_CUR && !periodic_upd_i
      |=> $stable(ptr_q[`LP_IDX_PER_CUR]);
  endproperty
  a_per_ro: assert property (p_per_ro)
    else $error("periodic pointer written");

  property p_rd_low_zero;
    clk_en_i && reg_re_i && rd_idx != `LP_IDX_NONE && rd_idx != `LP_IDX_COMM
      |=> reg_rdata_o[3:0] == 4'h0
          ##1 (!$past(clk_en_i) || $past(reg_re_i) || reg_rdata_o == '0);
  endproperty
  a_rd_low_zero: assert property (p_rd_low_zero)
    else $error("read data low bits or hold wrong");

  property p_ctl_end;
    clk_en_i && control_upd_i && control_ptr_i[31:4] == 28'h000_0000
      |=> control_list_end_o && ptr_q[`LP_IDX_CTL_CUR] == '0;
  endproperty
  a_ctl_end: assert property (p_ctl_end)
    else $error("control end not flagged");

  property p_ctl_hw_wins;
    clk_en_i && control_upd_i && reg_we_i && wr_idx == `LP_IDX_CTL_CUR
      |=> ptr_q[`LP_IDX_CTL_CUR] == {$past(control_ptr_i[31:4]), 4'h0};
  endproperty
  a_ctl_hw_wins: assert property (p_ctl_hw_wins)
    else $error("control advance lost");

  property p_blk_live;
    clk_en_i && bulk_upd_i && bulk_ptr_i[31:4] != 28'h000_0000
      |=> !bulk_list_end_o && ptr_q[`LP_IDX_BLK_CUR] == {$past(bulk_ptr_i[31:4]), 4'h0};
  endproperty
  a_blk_live: assert property (p_blk_live)
    else $error("bulk pointer wrong");

  property p_fetch;
    clk_en_i && fetch_req_i && fetch_sel_i == 2'h2
      |=> fetch_valid_o && fetch_addr_o == $past(ptr_q[`LP_IDX_CTL_CUR])
          && fetch_addr_o[3:0] == 4'h0;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch address wrong");

  property p_unmapped;
    clk_en_i && reg_re_i && rd_idx == `LP_IDX_NONE |=> reg_rdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_rd_idle;
    clk_en_i && !reg_re_i |=> reg_rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared");

  property p_ctl_head_load;
    clk_en_i && reg_we_i && wr_idx == `LP_IDX_CTL_HEAD
      |=> control_head_ptr_o == {$past(reg_wdata_i[31:4]), 4'h0};
  endproperty
  a_ctl_head_load: assert property (p_ctl_head_load)
    else $error("control head load wrong");

  property p_blk_head_load;
    clk_en_i && reg_we_i && wr_idx == `LP_IDX_BLK_HEAD
      |=> bulk_head_ptr_o == {$past(reg_wdata_i[31:4]), 4'h0};
  endproperty
  a_blk_head_load: assert property (p_blk_head_load)
    else $error("bulk head load wrong");

  property p_blk_end;
    clk_en_i && bulk_upd_i && bulk_ptr_i[31:4] == 28'h000_0000
      |=> bulk_list_end_o && ptr_q[`LP_IDX_BLK_CUR] == '0;
  endproperty
  a_blk_end: assert property (p_blk_end)
    else $error("bulk end not flagged");

  property p_ctl_live;
    clk_en_i && control_upd_i && control_ptr_i[31:4] != 28'h000_0000
      |=> !control_list_end_o && ptr_q[`LP_IDX_CTL_CUR] == {$past(control_ptr_i[31:4]), 4'h0};
  endproperty
  a_ctl_live: assert property (p_ctl_live)
    else $error("control pointer wrong");

  property p_blk_hw_wins;
    clk_en_i && bulk_upd_i && reg_we_i && wr_idx == `LP_IDX_BLK_CUR
      |=> ptr_q[`LP_IDX_BLK_CUR] == {$past(bulk_ptr_i[31:4]), 4'h0};
  endproperty
  a_blk_hw_wins: assert property (p_blk_hw_wins)
    else $error("bulk advance lost");

  property p_fetch_idle;
    clk_en_i && !fetch_req_i |=> !fetch_valid_o && $stable(fetch_addr_o);
  endproperty
  a_fetch_idle: assert property (p_fetch_idle)
    else $error("fetch output moved without request");

  property p_frozen;
    !clk_en_i |=> $stable(reg_rdata_o) && $stable(fetch_valid_o) && $stable(fetch_addr_o)
      && $stable(comm_base_o) && $stable(control_head_ptr_o) && $stable(bulk_head_ptr_o)
      && $stable(ptr_q[`LP_IDX_CTL_CUR]) && $stable(ptr_q[`LP_IDX_BLK_CUR]);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state changed while clock enable low");

  property p_cv_ctl_end;
    clk_en_i && control_upd_i ##1 control_list_end_o;
  endproperty
  c_cv_ctl_end: cover property (p_cv_ctl_end);

  property p_cv_collide;
    clk_en_i && bulk_upd_i && reg_we_i && wr_idx == `LP_IDX_BLK_CUR;
  endproperty
  c_cv_collide: cover property (p_cv_collide);

  property p_cv_rd_after_wr;
    clk_en_i && reg_we_i ##1 clk_en_i && reg_re_i;
  endproperty
  c_cv_rd_after_wr: cover property (p_cv_rd_after_wr);

  property p_cv_blk_end;
    clk_en_i && bulk_upd_i ##1 bulk_list_end_o;
  endproperty
  c_cv_blk_end: cover property (p_cv_blk_end);

  property p_cv_frozen;
    !clk_en_i && reg_we_i && bulk_upd_i;
  endproperty
  c_cv_frozen: cover property (p_cv_frozen);

endmodule : ohci_list_pointer_regs

// ### design/ptr_field_reg.sv
// One pointer register with software load and hardware advance.
// Assumes strobes synchronous to clk_sys_i.
`timescale 1ns/100ps
`include "list_ptr_map.svh"
module ptr_field_reg
  import list_ptr_pkg::*;
#(
  parameter int unsigned LSB   = `LP_ED_LSB,
  parameter bit          SW_WR = 1'b1
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  ptr_port_if.owner p
);

  logic [31:0] ptr_reg;
  logic [31:0] ptr_next;
  logic        end_reg;

  if (LSB < 1 || LSB > 31) begin : g_bad_lsb
    $error("ptr_field_reg: LSB out of range");
  end

  // ----------------------------------------------------------------
  // Next value: hardware advance wins over a software load.
  // ----------------------------------------------------------------
  always_comb begin
    ptr_next = ptr_reg;
    if (p.hw_we) begin
      ptr_next = pad_ptr(p.hw_wdata, LSB);
    end else if (SW_WR && p.sw_we) begin
      ptr_next = pad_ptr(p.sw_wdata, LSB);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr_reg <= `LP_PTR_RST;
    end else if (clk_en_i) begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      end_reg <= 1'b1;
    end else if (clk_en_i) begin
      end_reg <= (ptr_next == `LP_PTR_RST);
    end
  end

  assign p.ptr    = ptr_reg;
  assign p.at_end = end_reg;

endmodule : ptr_field_reg

// ### inc/list_ptr_map.svh
// Register offsets, field positions and reset values of the list pointer bank.
// Assumes byte addresses on a word-wide register port, one register per word.
// Contract
// - Keep base bits 31:8, low byte reads zero.
// - Report next periodic descriptor in bits 31:4.
// - Descriptors 16-byte aligned, bits 3:0 zero.
// - Control current zero means list end reached.
// - Hardware advances control current without software.
// - Hardware advances bulk current, zero means end.
`ifndef LIST_PTR_MAP_SVH
`define LIST_PTR_MAP_SVH

// ----------------------------------------------------------------
// Byte offsets.
// ----------------------------------------------------------------
`define LP_OFF_COMM_BASE 8'h00
`define LP_OFF_PER_CUR   8'h04
`define LP_OFF_CTL_HEAD  8'h08
`define LP_OFF_CTL_CUR   8'h0C
`define LP_OFF_BLK_HEAD  8'h10
`define LP_OFF_BLK_CUR   8'h14

// ----------------------------------------------------------------
// Register indices, fields and reset values.
// ----------------------------------------------------------------
`define LP_IDX_COMM      3'h0
`define LP_IDX_PER_CUR   3'h1
`define LP_IDX_CTL_HEAD  3'h2
`define LP_IDX_CTL_CUR   3'h3
`define LP_IDX_BLK_HEAD  3'h4
`define LP_IDX_BLK_CUR   3'h5
`define LP_IDX_NONE      3'h7
`define LP_NUM_REGS      6
`define LP_OFF_W         8
`define LP_COMM_LSB      8
`define LP_ED_LSB        4
`define LP_PTR_RST       32'h0000_0000

`endif

// ### inc/list_ptr_pkg.sv
// Types and shared helpers of the list pointer bank.
// Assumes nothing beyond the map header.
package list_ptr_pkg;

  typedef enum logic [1:0] {
    LIST_COMM,
    LIST_PERIODIC,
    LIST_CONTROL,
    LIST_BULK
  } list_sel_e;

  typedef logic [31:0] phys_addr_t;

  // Clears the address bits below the stored field.
  function automatic phys_addr_t pad_ptr(phys_addr_t a, int unsigned lsb);
    phys_addr_t m;
    m = '1;
    m = m << lsb;
    return a & m;
  endfunction : pad_ptr

endpackage : list_ptr_pkg

// ### inc/ptr_port_if.sv
// Connection between the bank and one pointer register.
// Assumes one owner module per instance.
`timescale 1ns/100ps
interface ptr_port_if;
  logic        sw_we;
  logic [31:0] sw_wdata;
  logic        hw_we;
  logic [31:0] hw_wdata;
  logic [31:0] ptr;
  logic        at_end;

  modport owner (input sw_we, input sw_wdata, input hw_we, input hw_wdata,
                 output ptr, output at_end);
  modport user  (output sw_we, output sw_wdata, output hw_we, output hw_wdata,
                 input ptr, input at_end);
endinterface : ptr_port_if

// ### tb/ohci_list_pointer_regs_test.sv
// Self-checking bench for the list pointer register bank.
// Assumes the map header and package are compiled first; clock enable driven here.
`timescale 1ns/100ps
`include "list_ptr_map.svh"
module ohci_list_pointer_regs_test;
  import list_ptr_pkg::*;

  // ----------------------------------------------------------------
  // Signals and model state.
  // ----------------------------------------------------------------
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        periodic_upd_i = 1'b0;
  logic        control_upd_i = 1'b0;
  logic        bulk_upd_i = 1'b0;
  logic [31:0] periodic_ptr_i = 32'h0000_0000;
  logic [31:0] control_ptr_i = 32'h0000_0000;
  logic [31:0] bulk_ptr_i = 32'h0000_0000;
  logic        fetch_req_i = 1'b0;
  logic [1:0]  fetch_sel_i = 2'h0;
  logic [31:0] fetch_addr_o, comm_base_o, control_head_ptr_o, bulk_head_ptr_o;
  logic        fetch_valid_o, control_list_end_o, bulk_list_end_o;
  int          bad_count = 0;
  int          checked = 0;
  int          seed = 32'h8b70bf97;
  logic [31:0] mdl [6];
  logic [31:0] msk [6] = '{32'hFFFF_FF00, 32'h0000_0000, 32'hFFFF_FFF0,
                           32'hFFFF_FFF0, 32'hFFFF_FFF0, 32'hFFFF_FFF0};
  logic [7:0]  offs [6] = '{`LP_OFF_COMM_BASE, `LP_OFF_PER_CUR, `LP_OFF_CTL_HEAD,
                            `LP_OFF_CTL_CUR, `LP_OFF_BLK_HEAD, `LP_OFF_BLK_CUR};
  int          fidx [4] = '{0, 1, 3, 5};

  always #10 clk_sys_i = ~clk_sys_i;

  ohci_list_pointer_regs DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .periodic_upd_i(periodic_upd_i), .periodic_ptr_i(periodic_ptr_i),
    .control_upd_i(control_upd_i), .control_ptr_i(control_ptr_i),
    .bulk_upd_i(bulk_upd_i), .bulk_ptr_i(bulk_ptr_i),
    .fetch_req_i(fetch_req_i), .fetch_sel_i(fetch_sel_i),
    .fetch_addr_o(fetch_addr_o), .fetch_valid_o(fetch_valid_o),
    .comm_base_o(comm_base_o), .control_head_ptr_o(control_head_ptr_o),
    .bulk_head_ptr_o(bulk_head_ptr_o), .control_list_end_o(control_list_end_o),
    .bulk_list_end_o(bulk_list_end_o));

  // ----------------------------------------------------------------
  // Compare and bus tasks.
  // ----------------------------------------------------------------
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b0;
    #1;
    chk_data(reg_rdata_o, exp);
  endtask : rd

  task automatic outs;
    #1;
    chk_data(comm_base_o, mdl[0]);
    chk_data(control_head_ptr_o, mdl[2]);
    chk_data(bulk_head_ptr_o, mdl[4]);
    chk_flag(control_list_end_o, mdl[3] == 32'h0);
    chk_flag(bulk_list_end_o, mdl[5] == 32'h0);
  endtask : outs

  task automatic readall;
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], mdl[i]);
    end
  endtask : readall

  task automatic upd(input int w, input logic [31:0] v);
    @(posedge clk_sys_i);
    case (w)
      1: begin periodic_upd_i <= 1'b1; periodic_ptr_i <= v; end
      3: begin control_upd_i <= 1'b1; control_ptr_i <= v; end
      default: begin bulk_upd_i <= 1'b1; bulk_ptr_i <= v; end
    endcase
    @(posedge clk_sys_i);
    periodic_upd_i <= 1'b0;
    control_upd_i  <= 1'b0;
    bulk_upd_i     <= 1'b0;
    mdl[w] = v & 32'hFFFF_FFF0;
  endtask : upd

  task automatic conclude;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    for (int i = 0; i < 6; i++) mdl[i] = 32'h0000_0000;
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    outs();
    readall();
    $display("test reset done");
    for (int n = 0; n < 4; n++) begin
      for (int i = 0; i < 6; i++) begin
        v = $random(seed);
        wr(offs[i], v);
        if (i != 1) mdl[i] = v & msk[i];
      end
      wr(8'h1C, $random(seed));
      outs();
      readall();
      rd(8'h1C, 32'h0000_0000);
    end
    $display("test software writes done");
    for (int n = 0; n < 6; n++) begin
      upd(1, $random(seed));
      upd(3, (n == 2) ? 32'h0000_0000 : $random(seed));
      upd(5, (n == 4) ? 32'h0000_000F : $random(seed));
      outs();
      readall();
    end
    $display("test walker advance done");
    for (int k = 3; k < 6; k += 2) begin
      v = $random(seed);
      @(posedge clk_sys_i);
      reg_we_i    <= 1'b1;
      reg_addr_i  <= offs[k];
      reg_wdata_i <= 32'h1234_5670;
      if (k == 3) begin
        control_upd_i <= 1'b1;
        control_ptr_i <= v;
      end else begin
        bulk_upd_i <= 1'b1;
        bulk_ptr_i <= v;
      end
      @(posedge clk_sys_i);
      reg_we_i      <= 1'b0;
      reg_re_i      <= 1'b1;
      control_upd_i <= 1'b0;
      bulk_upd_i    <= 1'b0;
      mdl[k] = v & 32'hFFFF_FFF0;
      @(posedge clk_sys_i);
      reg_re_i <= 1'b0;
      #1;
      chk_data(reg_rdata_o, mdl[k]);
      outs();
    end
    $display("test write collision done");
    @(posedge clk_sys_i);
    clk_en_i    <= 1'b0;
    reg_we_i    <= 1'b1;
    reg_addr_i  <= `LP_OFF_CTL_HEAD;
    reg_wdata_i <= $random(seed);
    bulk_upd_i  <= 1'b1;
    bulk_ptr_i  <= $random(seed);
    fetch_req_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b0;
    bulk_upd_i  <= 1'b0;
    fetch_req_i <= 1'b0;
    @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    outs();
    chk_flag(fetch_valid_o, 1'b0);
    chk_data(fetch_addr_o, 32'h0000_0000);
    readall();
    $display("test clock enable done");
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_sys_i);
      fetch_req_i <= 1'b1;
      fetch_sel_i <= n[1:0];
      @(posedge clk_sys_i);
      fetch_req_i <= 1'b0;
      #1;
      chk_flag(fetch_valid_o, 1'b1);
      chk_data(fetch_addr_o, mdl[fidx[n % 4]]);
      @(posedge clk_sys_i);
      #1;
      chk_flag(fetch_valid_o, 1'b0);
      if (n == 3) upd(5, $random(seed));
    end
    $display("test fetch done");
    conclude();
  end

endmodule : ohci_list_pointer_regs_test
